// ### cod_defines.svh
// object indices, field positions, reset values and timing counts of the dictionary
`ifndef COD_DEFINES_SVH
`define COD_DEFINES_SVH

`define COD_IDX_DEVICE_TYPE      16'h1000
`define COD_IDX_ERROR_FLAGS      16'h1001
`define COD_IDX_ERROR_HISTORY    16'h1003
`define COD_IDX_SYNC_ID          16'h1005
`define COD_IDX_SYNC_PERIOD      16'h1006
`define COD_IDX_NODE_NAME        16'h1008
`define COD_IDX_HW_VERSION       16'h1009
`define COD_IDX_SW_VERSION       16'h100a
`define COD_IDX_NODE_NUMBER      16'h100b

`define COD_ERR_VENDOR_BIT       7
`define COD_ERR_OVERRUN_BIT      4
`define COD_ERR_GENERIC_BIT      0
`define COD_ERR_FLAGS_RESET      8'h00

`define COD_HIST_DEPTH           10
`define COD_HIST_CNT_W           4
`define COD_SYNC_ID_W            11
`define COD_SYNC_PRODUCER_BIT    30
`define COD_SYNC_ID_RESET        32'h0000_0080
`define COD_SYNC_PERIOD_RESET    32'h0000_0000
`define COD_NODE_W               7
`define COD_EXPEDITED_MAX        4

`define COD_STR_BYTES            8
`define COD_LEN_W                4

`define COD_CLK_PERIOD_PS        4000
`define COD_US_IN_PS             1000000
`define COD_US_CYCLES            (`COD_US_IN_PS / `COD_CLK_PERIOD_PS)
`define COD_PRESC_W              8
`define COD_WD_W                 33
`define COD_IO_SYNC_LIMIT_MS     90
`define COD_IO_SYNC_LIMIT_US     (`COD_IO_SYNC_LIMIT_MS * 1000)

`endif

// ### cod_pkg.sv
// types shared by the dictionary and its byte serialiser
`include "cod_defines.svh"
package cod_pkg;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] index;
		logic [7:0]  subindex;
		logic [31:0] wdata;
	} cod_req_t;

	typedef struct packed {
		logic        valid;
		logic        vendor;
		logic        overrun;
		logic [15:0] add_code;
		logic [15:0] code;
	} cod_err_t;

	typedef struct packed {
		logic       byte_valid;
		logic [7:0] data;
		logic       done;
		logic       abort;
		logic       segmented;
	} cod_rsp_t;

	typedef struct packed {
		logic                         busy;
		logic [`COD_STR_BYTES*8-1:0]  buffer;
		logic [`COD_LEN_W-1:0]        remain;
		cod_rsp_t                     rsp;
	} cod_ser_state_t;

	typedef struct packed {
		logic                                  ready;
		logic [7:0]                            err_flags;
		logic [`COD_HIST_CNT_W-1:0]            hist_cnt;
		logic [`COD_HIST_DEPTH-1:0][31:0]      hist;
		logic [31:0]                           sync_id;
		logic [31:0]                           sync_period;
		logic [`COD_PRESC_W-1:0]               presc;
		logic [`COD_WD_W-1:0]                  wd_us;
		logic                                  sync_fault;
		logic                                  io_update;
		logic [`COD_NODE_W-1:0]                node_meta;
		logic [`COD_NODE_W-1:0]                node_sync;
	} cod_state_t;

endpackage : cod_pkg

// ### cod_byte_ser.sv
// serialiser that sends an object value byte by byte, least significant first
`timescale 1ns/10ps
`include "cod_defines.svh"
module cod_byte_ser (
	input  wire logic                         i_mclk,
	input  wire logic                         i_reset_n,
	input  wire logic                         i_load,
	input  wire logic                         i_abort,
	input  wire logic [`COD_STR_BYTES*8-1:0]  i_data,
	input  wire logic [`COD_LEN_W-1:0]        i_len,
	output cod_pkg::cod_rsp_t                 o_rsp,
	output logic                              o_busy
);

	cod_pkg::cod_ser_state_t q;
	cod_pkg::cod_ser_state_t d;

	always_comb begin
		d                = q;
		d.rsp.byte_valid = 1'b0;
		d.rsp.done       = 1'b0;
		d.rsp.abort      = 1'b0;
		if (i_load) begin
			// longer values need the segmented transfer
			d.rsp.segmented = (i_len > `COD_LEN_W'(`COD_EXPEDITED_MAX));
			if (i_abort) begin
				d.rsp.done  = 1'b1;
				d.rsp.abort = 1'b1;
				d.busy      = 1'b0;
			end else if (i_len == '0) begin
				d.rsp.done = 1'b1;
				d.busy     = 1'b0;
			end else begin
				d.rsp.byte_valid = 1'b1;
				d.rsp.data       = i_data[7:0];
				d.buffer         = i_data >> 8;
				d.remain         = i_len - `COD_LEN_W'(1);
				d.rsp.done       = (i_len == `COD_LEN_W'(1));
				d.busy           = (i_len > `COD_LEN_W'(1));
			end
		end else if (q.busy) begin
			d.rsp.byte_valid = 1'b1;
			d.rsp.data       = q.buffer[7:0];
			d.buffer         = q.buffer >> 8;
			d.remain         = q.remain - `COD_LEN_W'(1);
			d.rsp.done       = (q.remain == `COD_LEN_W'(1));
			d.busy           = (q.remain > `COD_LEN_W'(1));
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_rsp  = q.rsp;
	assign o_busy = q.busy;

endmodule : cod_byte_ser

// ### cod_dictionary.sv
// communication object dictionary of an i/o node: type, errors, sync and identity
//
// Behaviour
// - device type reads profile number low, signal-type field high, read-only
// - field bits 0..3: digital in, digital out, analog in, analog out
// - special-function terminals never contribute to the signal-type bits
// - error flags byte: bit7 vendor, bit4 overrun, bit0 generic, resets zero
// - every recorded error also sets the generic bit
// - history count at subindex 0, up to ten read-only 32-bit entries
// - newest error at subindex 1, older entries move up one
// - writing zero to subindex 0 discards the history, count reads zero
// - history empty after reset; only subindex 0 exists, reading zero
// - entry holds error code low half, trigger code high half
// - multi-byte values travel least significant byte first
// - sync identifier is the low 11 bits of a writable word, default 0x80
// - producer bit 30 always reads zero; bit 31 has no effect
// - nonzero period with synchronous transfer: missing sync means error state
// - watchdog time is one and a half sync periods
// - i/o updates on sync when all objects synchronous, period nonzero and period*type < 90 ms
// - name and version strings are returned by segmented transfer
// - node number reads as a read-only 32-bit object
`timescale 1ns/10ps
`include "cod_defines.svh"
module cod_dictionary #(
	// arbitrary value, stands in for the profile number
	parameter logic [15:0]                 PROFILE_NUMBER = 16'h0abc,
	parameter int                          STR_LEN        = `COD_STR_BYTES,
	parameter logic [`COD_STR_BYTES*8-1:0] NAME_STR       = 64'h3130_2d65_646f_6e6f,
	parameter logic [`COD_STR_BYTES*8-1:0] HW_VER_STR     = 64'h3030_2e31_2d77_6868,
	parameter logic [`COD_STR_BYTES*8-1:0] SW_VER_STR     = 64'h3030_2e31_2d77_7373
) (
	input  wire logic                    i_mclk,
	input  wire logic                    i_reset_n,
	input  cod_pkg::cod_req_t            i_req,
	output logic                         o_req_ready,
	output cod_pkg::cod_rsp_t            o_rsp,
	input  cod_pkg::cod_err_t            i_err,
	input  wire logic [3:0]              i_io_kinds,
	input  wire logic [`COD_NODE_W-1:0]  i_node_switch,
	input  wire logic                    i_sync_rx,
	input  wire logic                    i_sync_pdo_active,
	input  wire logic                    i_pdo_all_sync,
	input  wire logic [7:0]              i_pdo_min_type,
	output logic [`COD_SYNC_ID_W-1:0]    o_sync_cob_id,
	output logic                         o_sync_fault,
	output logic                         o_io_update,
	output logic [7:0]                   o_err_flags
);

	localparam logic [`COD_LEN_W-1:0] STR_LEN_L = `COD_LEN_W'(STR_LEN);
	localparam logic [`COD_PRESC_W-1:0] PRESC_LAST = `COD_PRESC_W'(`COD_US_CYCLES - 1);
	localparam logic [`COD_HIST_CNT_W-1:0] HIST_FULL = `COD_HIST_CNT_W'(`COD_HIST_DEPTH);
	localparam logic [39:0] IO_LIMIT = 40'(`COD_IO_SYNC_LIMIT_US);

	cod_pkg::cod_state_t q;
	cod_pkg::cod_state_t d;

	logic                        take;
	logic                        ser_busy;
	logic                        rsp_abort;
	logic [`COD_STR_BYTES*8-1:0] rsp_data;
	logic [`COD_LEN_W-1:0]       rsp_len;
	logic                        hist_clear;
	logic [`COD_WD_W-1:0]        wd_limit;
	logic [39:0]                 period_x_type;
	logic                        wd_armed;

	assign take = i_req.valid && q.ready;

	// period plus half period, in microseconds
	assign wd_limit = {1'b0, q.sync_period} + {2'b00, q.sync_period[31:1]};
	assign period_x_type = q.sync_period * i_pdo_min_type;
	// only armed with nonzero period during synchronous transfer
	assign wd_armed = (q.sync_period != '0) && i_sync_pdo_active;

	always_comb begin
		int sub;
		sub        = 0;
		d          = q;
		rsp_abort  = 1'b0;
		rsp_data   = '0;
		rsp_len    = '0;
		hist_clear = 1'b0;
		d.io_update = 1'b0;
		d.node_meta = i_node_switch;
		d.node_sync = q.node_meta;
		sub = int'(i_req.subindex);

		if (i_req.index == `COD_IDX_DEVICE_TYPE) begin
			// only four low field bits used
			rsp_data  = {32'h0, 12'h000, i_io_kinds, PROFILE_NUMBER};
			rsp_len   = `COD_LEN_W'(4);
			rsp_abort = i_req.write;
		end else if (i_req.index == `COD_IDX_ERROR_FLAGS) begin
			rsp_data  = {56'h0, q.err_flags};
			rsp_len   = `COD_LEN_W'(1);
			rsp_abort = i_req.write;
		end else if (i_req.index == `COD_IDX_ERROR_HISTORY) begin
			if (i_req.subindex == 8'h00) begin
				rsp_data = {60'h0, q.hist_cnt};
				rsp_len  = `COD_LEN_W'(1);
				if (i_req.write) begin
					rsp_abort  = (i_req.wdata != '0);
					hist_clear = (i_req.wdata == '0);
					rsp_len    = '0;
				end
			end else if (sub <= int'(q.hist_cnt)) begin
				// entries beyond count do not exist
				rsp_data  = {32'h0, q.hist[sub-1]};
				rsp_len   = `COD_LEN_W'(4);
				rsp_abort = i_req.write;
			end else begin
				rsp_abort = 1'b1;
			end
		end else if (i_req.index == `COD_IDX_SYNC_ID) begin
			rsp_data = {32'h0, q.sync_id};
			rsp_len  = `COD_LEN_W'(4);
			if (i_req.write) begin
				rsp_len   = '0;
				d.sync_id = i_req.wdata;
				// consumer only, producer bit held clear
				d.sync_id[`COD_SYNC_PRODUCER_BIT] = 1'b0;
			end
		end else if (i_req.index == `COD_IDX_SYNC_PERIOD) begin
			rsp_data = {32'h0, q.sync_period};
			rsp_len  = `COD_LEN_W'(4);
			if (i_req.write) begin
				rsp_len       = '0;
				d.sync_period = i_req.wdata;
			end
		end else if (i_req.index == `COD_IDX_NODE_NAME) begin
			rsp_data  = NAME_STR;
			rsp_len   = STR_LEN_L;
			rsp_abort = i_req.write;
		end else if (i_req.index == `COD_IDX_HW_VERSION) begin
			rsp_data  = HW_VER_STR;
			rsp_len   = STR_LEN_L;
			rsp_abort = i_req.write;
		end else if (i_req.index == `COD_IDX_SW_VERSION) begin
			rsp_data  = SW_VER_STR;
			rsp_len   = STR_LEN_L;
			rsp_abort = i_req.write;
		end else if (i_req.index == `COD_IDX_NODE_NUMBER) begin
			// switch value widened to 32 bits
			rsp_data  = {57'h0, q.node_sync};
			rsp_len   = `COD_LEN_W'(4);
			rsp_abort = i_req.write;
		end else begin
			rsp_abort = 1'b1;
		end

		// a refused access must leave state untouched
		if (!take || rsp_abort) begin
			d.sync_id     = q.sync_id;
			d.sync_period = q.sync_period;
			hist_clear    = 1'b0;
		end

		// clear first so a same-cycle error still lands
		if (hist_clear) begin
			d.hist_cnt  = '0;
			d.err_flags = `COD_ERR_FLAGS_RESET;
		end

		if (i_err.valid) begin
			for (int i = `COD_HIST_DEPTH - 1; i > 0; i--) begin
				d.hist[i] = q.hist[i-1];
			end
			d.hist[0] = {i_err.add_code, i_err.code};
			// saturate at ten, oldest falls out
			if (d.hist_cnt != HIST_FULL) begin
				d.hist_cnt = d.hist_cnt + `COD_HIST_CNT_W'(1);
			end
			d.err_flags[`COD_ERR_GENERIC_BIT] = 1'b1;
			if (i_err.vendor) begin
				d.err_flags[`COD_ERR_VENDOR_BIT] = 1'b1;
			end
			if (i_err.overrun) begin
				d.err_flags[`COD_ERR_OVERRUN_BIT] = 1'b1;
			end
		end

		// microsecond watchdog, restarted by each sync
		if (!wd_armed || i_sync_rx) begin
			d.presc = '0;
			d.wd_us = '0;
		end else if (q.presc == PRESC_LAST) begin
			d.presc = '0;
			// magnitude compare: a shortened period must not let the count run past
			if (q.wd_us < wd_limit) begin
				d.wd_us = q.wd_us + `COD_WD_W'(1);
			end
		end else begin
			d.presc = q.presc + `COD_PRESC_W'(1);
		end
		// error state held until sync returns or the watchdog is disarmed
		if (i_sync_rx || !wd_armed) begin
			d.sync_fault = 1'b0;
		end else if (q.wd_us >= wd_limit) begin
			d.sync_fault = 1'b1;
		end

		// immediate update only under the timing condition
		if (i_sync_rx && i_pdo_all_sync && (q.sync_period != '0)
				&& (period_x_type < IO_LIMIT)) begin
			d.io_update = 1'b1;
		end

		// one idle cycle after each answer before the next request
		d.ready = !take && !ser_busy;
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q             <= '0;
			q.ready       <= 1'b1;
			q.err_flags   <= `COD_ERR_FLAGS_RESET;
			q.hist_cnt    <= '0;
			q.sync_id     <= `COD_SYNC_ID_RESET;
			q.sync_period <= `COD_SYNC_PERIOD_RESET;
		end else begin
			q <= d;
		end
	end

	cod_byte_ser u_ser (
		.i_mclk    (i_mclk),
		.i_reset_n (i_reset_n),
		.i_load    (take),
		.i_abort   (rsp_abort),
		.i_data    (rsp_data),
		.i_len     (rsp_len),
		.o_rsp     (o_rsp),
		.o_busy    (ser_busy)
	);

	assign o_req_ready   = q.ready;
	// filter id from low bits; bit 31 ignored
	assign o_sync_cob_id = q.sync_id[`COD_SYNC_ID_W-1:0];
	assign o_sync_fault  = q.sync_fault;
	assign o_io_update   = q.io_update;
	assign o_err_flags   = q.err_flags;

endmodule : cod_dictionary

// ### cod_dictionary_asserts.sv
// checker on the dictionary ports
`timescale 1ns/10ps
`include "cod_defines.svh"
module cod_dictionary_asserts (
	input wire logic                       i_mclk,
	input wire logic                       i_reset_n,
	input cod_pkg::cod_req_t               i_req,
	input wire logic                       o_req_ready,
	input cod_pkg::cod_rsp_t               o_rsp,
	input cod_pkg::cod_err_t               i_err,
	input wire logic                       i_sync_rx,
	input wire logic                       i_pdo_all_sync,
	input wire logic [`COD_SYNC_ID_W-1:0]  o_sync_cob_id,
	input wire logic                       o_sync_fault,
	input wire logic                       o_io_update,
	input wire logic [7:0]                 o_err_flags
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	logic take;
	assign take = i_req.valid && o_req_ready;
	sequence s_word_bytes;
		(o_rsp.byte_valid && !o_rsp.done) [*3] ##1 (o_rsp.byte_valid && o_rsp.done);
	endsequence
	a_sync_word_bytes: assert property (take && !i_req.write && i_req.index == 16'h1005
		|=> s_word_bytes) else $error("sync word not four bytes");
	a_sync_id_out: assert property (take && i_req.write && i_req.index == 16'h1005
		|=> o_sync_cob_id == $past(i_req.wdata[10:0])) else $error("sync id not taken");
	a_type_write_abort: assert property (take && i_req.write && i_req.index == 16'h1000
		|=> o_rsp.done && o_rsp.abort) else $error("type write not refused");
	a_string_segmented: assert property (take && !i_req.write
		&& i_req.index inside {16'h1008, 16'h1009, 16'h100a}
		|=> o_rsp.segmented ##7 o_rsp.done) else $error("string not segmented");
	a_generic_flag_set: assert property (i_err.valid |=> o_err_flags[0])
		else $error("generic flag missing");
	a_vendor_flag_set: assert property (i_err.valid && i_err.vendor |=> o_err_flags[7])
		else $error("vendor flag missing");
	a_reserved_flags_zero: assert property (
		o_err_flags[6:5] == 2'h0 && o_err_flags[3:1] == 3'h0)
		else $error("reserved flag set");
	a_io_update_cause: assert property (
		o_io_update |-> $past(i_sync_rx) && $past(i_pdo_all_sync))
		else $error("update without sync");
	a_fault_cleared: assert property (i_sync_rx |=> !o_sync_fault)
		else $error("fault not cleared by sync");
endmodule : cod_dictionary_asserts
bind cod_dictionary cod_dictionary_asserts cod_dictionary_asserts_i (
	.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_req(i_req), .o_req_ready(o_req_ready),
	.o_rsp(o_rsp), .i_err(i_err), .i_sync_rx(i_sync_rx), .i_pdo_all_sync(i_pdo_all_sync),
	.o_sync_cob_id(o_sync_cob_id), .o_sync_fault(o_sync_fault), .o_io_update(o_io_update),
	.o_err_flags(o_err_flags));

// ### cod_master_model.sv
// master side: collects answer bytes into a value
`timescale 1ns/10ps
module cod_master_model (
	input wire logic          i_mclk,
	input wire logic          i_reset_n,
	input cod_pkg::cod_req_t  i_req,
	input wire logic          i_req_ready,
	input cod_pkg::cod_rsp_t  i_rsp,
	output logic [63:0]       o_value,
	output logic [3:0]        o_count,
	output logic              o_fin,
	output logic              o_abort,
	output logic              o_seg
);
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_value <= '0;
			o_count <= '0;
			o_fin <= 1'b0;
			o_abort <= 1'b0;
			o_seg <= 1'b0;
		end else if (i_req.valid && i_req_ready) begin
			o_value <= '0;
			o_count <= '0;
			o_fin <= 1'b0;
		end else begin
			if (i_rsp.byte_valid) begin
				o_value[o_count*8 +: 8] <= i_rsp.data;
				o_count <= o_count + 4'h1;
			end
			if (i_rsp.done) begin
				o_fin <= 1'b1;
				o_abort <= i_rsp.abort;
				o_seg <= i_rsp.segmented;
			end
		end
	end
endmodule : cod_master_model

// ### cod_dictionary_bench.sv
// testbench of the object dictionary
`timescale 1ns/10ps
module cod_dictionary_bench;
	localparam logic [15:0] PROF = 16'h0123;
	localparam logic [63:0] STRS [3] = '{64'h6162_6364_6566_6768, 64'h3132_3334_3536_3738,
		64'h4142_4344_4546_4748};
	logic               i_mclk = 1'b0;
	logic               i_reset_n = 1'b0;
	cod_pkg::cod_req_t  req = '0;
	cod_pkg::cod_rsp_t  rsp;
	cod_pkg::cod_err_t  err = '0;
	logic [3:0]         kinds = 4'h0;
	logic [6:0]         node = 7'h2a;
	logic               sync_rx = 1'b0;
	logic               active = 1'b0;
	logic               all_sync = 1'b1;
	logic [7:0]         min_type = 8'h01;
	logic               rdy, fault, upd, fin, ab, seg;
	logic [10:0]        cob;
	logic [7:0]         flags;
	logic [63:0]        val;
	logic [3:0]         cnt;
	int                 n_fail = 0;
	int                 check_count = 0;
	int                 cycles = 0;
	always #2 i_mclk = ~i_mclk;
	cod_dictionary #(.PROFILE_NUMBER(PROF), .NAME_STR(STRS[0]), .HW_VER_STR(STRS[1]),
		.SW_VER_STR(STRS[2])) cod_dictionary_i (
		.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_req(req), .o_req_ready(rdy), .o_rsp(rsp),
		.i_err(err), .i_io_kinds(kinds), .i_node_switch(node), .i_sync_rx(sync_rx),
		.i_sync_pdo_active(active), .i_pdo_all_sync(all_sync), .i_pdo_min_type(min_type),
		.o_sync_cob_id(cob), .o_sync_fault(fault), .o_io_update(upd), .o_err_flags(flags));
	cod_master_model cod_master_model_i (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_req(req),
		.i_req_ready(rdy), .i_rsp(rsp), .o_value(val), .o_count(cnt), .o_fin(fin),
		.o_abort(ab), .o_seg(seg));
	task tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	always @(posedge i_mclk) begin
		cycles++;
		// ceiling well above the sync test length
		if (cycles == 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// one access; for reads d is the expected value, nb the byte count
	task op(input logic w, input logic [15:0] ix, input logic [7:0] sb, input logic [63:0] d,
		input logic [3:0] nb, input logic e_ab);
		int t;
		t = 0;
		while (rdy !== 1'b1 && t < 50) begin
			@(posedge i_mclk);
			#1;
			t++;
		end
		chk("ready", 1, rdy);
		req = '{1'b1, w, ix, sb, d[31:0]};
		@(posedge i_mclk);
		#1;
		req.valid = 1'b0;
		t = 0;
		while (fin !== 1'b1 && t < 50) begin
			@(posedge i_mclk);
			#1;
			t++;
		end
		chk("finished", 1, fin);
		chk("abort", e_ab, ab);
		if (!w && !e_ab) begin
			chk("bytes", nb, cnt);
			chk("value", d, val);
			chk("segmented", nb > 4, seg);
		end
	endtask : op
	task sy(input logic e);
		sync_rx = 1'b1;
		@(posedge i_mclk);
		#1;
		sync_rx = 1'b0;
		chk("io_update", e, upd);
		chk("fault", 0, fault);
	endtask : sy
	initial begin
		repeat (12) @(posedge i_mclk);
		#1;
		i_reset_n = 1'b1;
		op(0, 16'h1001, 0, 64'h0, 1, 0);
		op(0, 16'h1003, 0, 64'h0, 1, 0);
		op(0, 16'h1003, 1, 64'h0, 0, 1);
		for (int k = 0; k < 5; k++) begin
			// k == 4 stands for special-function terminals only
			kinds = (k < 4) ? 4'h1 << k : 4'h0;
			repeat (3) @(posedge i_mclk);
			#1;
			op(0, 16'h1000, 0, {32'h0, 12'h0, kinds, PROF}, 4, 0);
		end
		op(1, 16'h1000, 0, 64'h5, 0, 1);
		$display("test type done");
		op(0, 16'h1005, 0, 64'h80, 4, 0);
		op(1, 16'h1005, 0, 64'hc000_0123, 0, 0);
		op(0, 16'h1005, 0, 64'h8000_0123, 4, 0);
		chk("cob_id", 11'h123, cob);
		$display("test sync id done");
		for (int i = 1; i <= 11; i++) begin
			err = '{1'b1, i == 11, i == 5, 16'h00a0 + 16'(i), 16'h1000 + 16'(i)};
			@(posedge i_mclk);
			#1;
		end
		err = '0;
		op(0, 16'h1003, 0, 64'ha, 1, 0);
		op(0, 16'h1003, 1, 64'h00ab_100b, 4, 0);
		op(0, 16'h1003, 10, 64'h00a2_1002, 4, 0);
		op(0, 16'h1001, 0, 64'h91, 1, 0);
		chk("err_flags", 8'h91, flags);
		op(1, 16'h1003, 0, 64'h1, 0, 1);
		op(1, 16'h1003, 0, 64'h0, 0, 0);
		op(0, 16'h1003, 0, 64'h0, 1, 0);
		op(0, 16'h1003, 1, 64'h0, 0, 1);
		// an error on the clearing edge must survive the clear
		err = '{1'b1, 1'b0, 1'b0, 16'h00c1, 16'h20c1};
		fork
			op(1, 16'h1003, 0, 64'h0, 0, 0);
			begin
				@(posedge i_mclk);
				#1;
				err = '0;
			end
		join
		op(0, 16'h1003, 0, 64'h1, 1, 0);
		op(0, 16'h1003, 1, 64'h00c1_20c1, 4, 0);
		chk("err_flags", 8'h01, flags);
		// reset in mid-run empties the history again
		i_reset_n = 1'b0;
		repeat (2) @(posedge i_mclk);
		#1;
		i_reset_n = 1'b1;
		chk("err_flags", 8'h00, flags);
		op(0, 16'h1003, 0, 64'h0, 1, 0);
		op(0, 16'h1003, 1, 64'h0, 0, 1);
		op(0, 16'h1005, 0, 64'h80, 4, 0);
		$display("test history done");
		for (int s = 0; s < 3; s++)
			op(0, 16'h1008 + 16'(s), 0, STRS[s], 8, 0);
		op(0, 16'h100b, 0, 64'h2a, 4, 0);
		$display("test identity done");
		active = 1'b1;
		op(1, 16'h1006, 0, 64'h2, 0, 0);
		// one period is 500 clocks, watchdog ends near 750
		repeat (650) @(posedge i_mclk);
		#1;
		chk("fault early", 0, fault);
		repeat (150) @(posedge i_mclk);
		#1;
		chk("fault late", 1, fault);
		sy(1);
		op(1, 16'h1006, 0, 64'd400, 0, 0);
		min_type = 8'd240;
		sy(0);
		min_type = 8'd200;
		sy(1);
		all_sync = 1'b0;
		sy(0);
		all_sync = 1'b1;
		op(1, 16'h1006, 0, 64'h0, 0, 0);
		sy(0);
		// no synchronous transfer: watchdog stays disarmed
		active = 1'b0;
		op(1, 16'h1006, 0, 64'h2, 0, 0);
		repeat (800) @(posedge i_mclk);
		#1;
		chk("fault idle", 0, fault);
		$display("test sync period done");
		tally_and_finish();
	end
endmodule : cod_dictionary_bench
